// [design/rsld_top.v]
// Strap latch and decoder: captures sixteen straps and drives settings.
//
// What this block does
// R01 - While hardware reset is low the sixteen code-memory address pins stay inputs.
// R02 - On release of hardware reset the sixteen pin levels are stored as a word.
// R03 - The stored word is readable by the embedded controller and by the host port.
// R04 - A pin without external pull-up reads zero and a pulled-up pin reads one.
// R05 - Strap bits 6:0 form the seven-bit two-wire host slave address.
// R06 - The board straps bit 7 to zero to get two-wire host operation.
// R07 - The board straps bit 8 to zero for two-wire host operation.
// R08 - Strap bit 9 starts the controller on a stable clock, else waits for enable.
// R09 - Strap bit 12 picks the display-channel pair: zero dedicated, one host pins.
// R10 - Strap bits 11:10 choose the firmware serial baud rate code.
// R11 - Strap bit 13 picks crystal (zero) or single-ended oscillator (one).
// R12 - Strap bit 14 with control bit 4 of register 0x22 sets the code layout.
// R13 - An internal boot checks 89 ab cd ef at 0xfffc..0xffff and then runs from 0x0000.
// R14 - Strap bit 15 sets the panel-bias level after the reset sequence.
// R15 - Capture happens on the rising edge of the active-low hardware reset.
// R16 - The stored word holds until the next hardware reset, whatever the pins do.
`timescale 1ns/1ps
`default_nettype none
`include "rsld_regs.vh"

module rsld_top
(
    // Clock and system reset
    input wire clk_i,
    input wire reset_i,

    // Hardware reset pin, active low
    input wire hardware_reset_low_i,

    // Shared code-memory address pins
    input wire [15:0] code_addr_i,
    output reg [15:0] code_addr_o,
    output reg code_addr_oe_n_o,

    // External code-memory data
    input wire [7:0] code_data_i,

    // Embedded controller side
    input wire [15:0] fetch_addr_i,
    input wire layout_split_i,
    input wire mcu_enable_i,
    input wire mcu_clock_stable_i,
    output reg [15:0] config_word_o,
    output reg config_valid_o,
    output reg mcu_run_o,
    output reg fetch_external_o,
    output reg boot_external_o,
    output reg [15:0] mcu_start_addr_o,

    // Host register port read of the stored word
    input wire host_read_i,
    output reg [15:0] host_read_data_o,
    output reg host_read_valid_o,

    // Decoded settings
    output reg [6:0] host_slave_addr_o,
    output reg host_two_wire_o,
    output reg display_channel_pair_o,
    output reg [1:0] baud_choice_o,
    output reg refclk_source_o,
    output reg code_store_layout_o,
    output reg panel_bias_output_o
);

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    wire [15:0] strap_word;
    wire strap_captured;
    wire strap_pulse;

    // R04 pin level taken as is
    rsld_capture u_capture
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .hardware_reset_low_i(hardware_reset_low_i),
        .pins_i(code_addr_i),
        .word_o(strap_word),
        .captured_o(strap_captured),
        .capture_pulse_o(strap_pulse)
    );

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    wire autorun_strap;
    wire layout_strap;
    wire probe_start;

    assign autorun_strap = strap_word[`RSLD_AUTORUN_BIT];
    assign layout_strap = strap_word[`RSLD_LAYOUT_BIT];

    // The probe only runs for an internal boot; an external layout has no signature.
    assign probe_start = strap_pulse & ~layout_strap;

    // ----------------------------------------------------------------
    // Signature probe
    // ----------------------------------------------------------------
    wire [15:0] probe_addr;
    wire probe_busy;
    wire probe_done;
    wire probe_found;

    rsld_sig_probe u_probe
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(probe_start),
        .data_i(code_data_i),
        .addr_o(probe_addr),
        .busy_o(probe_busy),
        .done_o(probe_done),
        .found_o(probe_found)
    );

    // A found flag left over from an earlier release must not count, so the result
    // is trusted only for an internal layout and once the new probe has finished.
    wire probe_valid;
    assign probe_valid = probe_found & ~layout_strap & ~strap_pulse & ~probe_busy;

    // ----------------------------------------------------------------
    // Boot sequencing
    // ----------------------------------------------------------------
    reg boot_ready;
    reg next_boot_ready;
    reg next_fetch_ext;
    reg [15:0] next_addr;

    always @*
    begin
        next_boot_ready = boot_ready;
        if (!strap_captured)
            next_boot_ready = 1'b0;
        else if (layout_strap & strap_pulse)
            next_boot_ready = 1'b1;
        else if (probe_done & ~probe_busy & ~strap_pulse)
            next_boot_ready = 1'b1;
    end

    // ----------------------------------------------------------------
    // Code layout routing
    // ----------------------------------------------------------------
    // R12 code layout routing
    always @*
    begin
        next_fetch_ext = 1'b0;
        next_addr = fetch_addr_i;
        if (probe_valid)
            next_fetch_ext = 1'b1;
        else if (layout_strap & ~layout_split_i)
            next_fetch_ext = 1'b1;
        else if (layout_strap & layout_split_i & fetch_addr_i[`RSLD_SPLIT_BIT])
        begin
            next_fetch_ext = 1'b1;
            next_addr = {2'b00, fetch_addr_i[`RSLD_SPLIT_ADDR_W-1:0]};
        end
    end

    // ----------------------------------------------------------------
    // Controller start
    // ----------------------------------------------------------------
    reg next_mcu_run;

    // Once released the controller keeps running until the next hardware reset,
    // so a brief drop of its enable or clock-stable flag cannot stop it.
    // R08 controller start condition
    always @*
    begin
        next_mcu_run = mcu_run_o;
        if (!hardware_reset_low_i || !boot_ready)
            next_mcu_run = 1'b0;
        else if (autorun_strap)
            next_mcu_run = mcu_run_o | mcu_clock_stable_i;
        else
            next_mcu_run = mcu_run_o | mcu_enable_i;
    end

    // ----------------------------------------------------------------
    // Pin direction and fetch routing
    // ----------------------------------------------------------------
    // The pins turn to outputs only after the word is stored, so a driven
    // level can never reach the capture flops in place of a strap.
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            code_addr_oe_n_o <= 1'b1;
            code_addr_o <= 16'h0000;
            fetch_external_o <= 1'b0;
        end
        else
        begin
            // R01 pins stay inputs in reset
            // R16 drive only after capture
            if (!hardware_reset_low_i || !strap_captured)
            begin
                code_addr_oe_n_o <= 1'b1;
                code_addr_o <= 16'h0000;
            end
            else
            begin
                code_addr_oe_n_o <= 1'b0;
                code_addr_o <= probe_busy ? probe_addr : next_addr;
            end
            // R12 external fetch flag
            fetch_external_o <= strap_captured & ~probe_busy & next_fetch_ext;
        end
    end

    // ----------------------------------------------------------------
    // Stored word and host read port
    // ----------------------------------------------------------------
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            config_word_o <= `RSLD_WORD_RESET;
            config_valid_o <= 1'b0;
            host_read_data_o <= 16'h0000;
            host_read_valid_o <= 1'b0;
        end
        else
        begin
            // R03 controller copy of word
            config_word_o <= strap_word;
            config_valid_o <= strap_captured;

            // R03 host port read
            // The answer is held between requests for a slow host; only the
            // valid pulse marks it as fresh.
            host_read_valid_o <= host_read_i;
            if (host_read_i)
                host_read_data_o <= strap_word;
        end
    end

    // ----------------------------------------------------------------
    // Decoded settings
    // ----------------------------------------------------------------
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            host_slave_addr_o <= 7'h00;
            host_two_wire_o <= 1'b0;
            display_channel_pair_o <= 1'b0;
            baud_choice_o <= 2'b00;
            refclk_source_o <= 1'b0;
            code_store_layout_o <= 1'b0;
            panel_bias_output_o <= 1'b0;
        end
        else
        begin
            // R05 slave address field
            host_slave_addr_o <= strap_word[`RSLD_ADDR_MSB:`RSLD_ADDR_LSB];
            // R06 protocol strap zero
            // R07 port gate strap zero
            host_two_wire_o <= strap_captured & ~strap_word[`RSLD_PROTOCOL_BIT]
                & ~strap_word[`RSLD_PORT_GATE_BIT];

            // R09 display pair select
            display_channel_pair_o <= strap_word[`RSLD_PAIR_BIT];
            // R10 baud rate code
            baud_choice_o <= strap_word[`RSLD_BAUD_HI_BIT:`RSLD_BAUD_LO_BIT];
            // R11 reference clock source
            refclk_source_o <= strap_word[`RSLD_REFCLK_BIT];
            // R12 layout strap copy
            code_store_layout_o <= layout_strap;

            // R14 panel bias level
            // Bias is held low until the strap is known; the board's choice
            // takes effect from capture on.
            panel_bias_output_o <= strap_captured & strap_word[`RSLD_BIAS_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Boot state and controller release
    // ----------------------------------------------------------------
    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            boot_ready <= 1'b0;
            mcu_run_o <= 1'b0;
            boot_external_o <= 1'b0;
            mcu_start_addr_o <= `RSLD_BOOT_ADDR;
        end
        else
        begin
            boot_ready <= next_boot_ready;
            // R08 controller release
            mcu_run_o <= next_mcu_run;
            // R13 jump to external start
            boot_external_o <= probe_valid & strap_captured;
            mcu_start_addr_o <= `RSLD_BOOT_ADDR;
        end
    end

endmodule
`default_nettype wire

// [design/rsld_regs.vh]
// Strap field positions, reset values and timing counts for the strap latch.
`ifndef RSLD_REGS_VH
`define RSLD_REGS_VH

// ----------------------------------------------------------------
// Strap word layout
// ----------------------------------------------------------------
`define RSLD_STRAP_W 16
`define RSLD_ADDR_MSB 6
`define RSLD_ADDR_LSB 0
`define RSLD_PROTOCOL_BIT 7
`define RSLD_PORT_GATE_BIT 8
`define RSLD_AUTORUN_BIT 9
`define RSLD_BAUD_LO_BIT 10
`define RSLD_BAUD_HI_BIT 11
`define RSLD_PAIR_BIT 12
`define RSLD_REFCLK_BIT 13
`define RSLD_LAYOUT_BIT 14
`define RSLD_BIAS_BIT 15

// ----------------------------------------------------------------
// Reset values and code-memory constants
// ----------------------------------------------------------------
`define RSLD_WORD_RESET 16'h0000
`define RSLD_SPLIT_BIT 15
`define RSLD_SPLIT_ADDR_W 14
`define RSLD_BOOT_ADDR 16'h0000
`define RSLD_SIG_BASE 16'hfffc
`define RSLD_SIG_BYTE0 8'h89
`define RSLD_SIG_BYTE1 8'hab
`define RSLD_SIG_BYTE2 8'hcd
`define RSLD_SIG_BYTE3 8'hef

// ----------------------------------------------------------------
// Timing: external code-memory access time, rounded up to cycles
// ----------------------------------------------------------------
`define RSLD_CLK_MHZ 200
`define RSLD_ROM_ACCESS_NS 100
`define RSLD_ROM_WAIT_CYC ((`RSLD_ROM_ACCESS_NS * `RSLD_CLK_MHZ + 999) / 1000)

`endif

// [design/rsld_capture.v]
// Strap capture register: samples the pins on release of hardware reset.
`timescale 1ns/1ps
`default_nettype none
`include "rsld_regs.vh"

module rsld_capture
(
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Hardware reset pin and strap pins
    input wire hardware_reset_low_i,
    input wire [15:0] pins_i,
    // Captured word
    output reg [15:0] word_o,
    output reg captured_o,
    output reg capture_pulse_o
);

    reg hw_prev;
    wire release_edge;

    assign release_edge = hardware_reset_low_i & ~hw_prev;

    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            hw_prev <= 1'b0;
            word_o <= `RSLD_WORD_RESET;
            captured_o <= 1'b0;
            capture_pulse_o <= 1'b0;
        end
        else
        begin
            hw_prev <= hardware_reset_low_i;
            capture_pulse_o <= release_edge;
            // R15 rising edge capture
            // R02 latch pin levels
            if (release_edge)
            begin
                word_o <= pins_i;
                captured_o <= 1'b1;
            end
            else if (!hardware_reset_low_i)
                captured_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// [design/rsld_sig_probe.v]
// Boot probe: reads four signature bytes from external code memory.
`timescale 1ns/1ps
`default_nettype none
`include "rsld_regs.vh"

module rsld_sig_probe
(
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Control
    input wire start_i,
    input wire [7:0] data_i,
    // Probe results
    output reg [15:0] addr_o,
    output reg busy_o,
    output reg done_o,
    output reg found_o
);

    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_DONE = 2'd2;
    localparam integer WAIT_FULL = `RSLD_ROM_WAIT_CYC;
    localparam [7:0] WAIT_CYC = WAIT_FULL[7:0];

    reg [1:0] state;
    reg [1:0] idx;
    reg [7:0] wait_cnt;
    reg match;
    reg [7:0] expect_byte;

    always @*
    begin
        case (idx)
            2'd0: expect_byte = `RSLD_SIG_BYTE0;
            2'd1: expect_byte = `RSLD_SIG_BYTE1;
            2'd2: expect_byte = `RSLD_SIG_BYTE2;
            default: expect_byte = `RSLD_SIG_BYTE3;
        endcase
    end

    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state <= ST_IDLE;
            idx <= 2'd0;
            wait_cnt <= 8'h00;
            match <= 1'b0;
            addr_o <= `RSLD_SIG_BASE;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            found_o <= 1'b0;
        end
        else
        begin
            case (state)
                // A start seen after a finished probe restarts it, so no result is carried over.
                ST_IDLE, ST_DONE:
                begin
                    if (start_i)
                    begin
                        state <= ST_WAIT;
                        idx <= 2'd0;
                        wait_cnt <= WAIT_CYC;
                        match <= 1'b1;
                        addr_o <= `RSLD_SIG_BASE;
                        busy_o <= 1'b1;
                        done_o <= 1'b0;
                        found_o <= 1'b0;
                    end
                end
                ST_WAIT:
                begin
                    // R13 compare signature bytes
                    if (wait_cnt != 8'h01)
                        wait_cnt <= wait_cnt - 8'h01;
                    else if (idx == 2'd3)
                    begin
                        state <= ST_DONE;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        found_o <= match & (data_i == expect_byte);
                    end
                    else
                    begin
                        match <= match & (data_i == expect_byte);
                        idx <= idx + 2'd1;
                        addr_o <= addr_o + 16'h0001;
                        wait_cnt <= WAIT_CYC;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// [sim/rsld_asserts.sv]
// Concurrent checks on the ports of the strap latch top.
`timescale 1ns/1ps
`default_nettype none

module rsld_asserts
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Watched ports
    input wire logic hardware_reset_low_i,
    input wire logic [15:0] code_addr_i,
    input wire logic code_addr_oe_n_o,
    input wire logic host_read_i,
    input wire logic [15:0] host_read_data_o,
    input wire logic host_read_valid_o,
    input wire logic [15:0] config_word_o,
    input wire logic config_valid_o,
    input wire logic mcu_run_o,
    input wire logic boot_external_o,
    input wire logic [15:0] mcu_start_addr_o,
    input wire logic [6:0] host_slave_addr_o,
    input wire logic host_two_wire_o,
    input wire logic display_channel_pair_o,
    input wire logic [1:0] baud_choice_o,
    input wire logic refclk_source_o,
    input wire logic code_store_layout_o,
    input wire logic panel_bias_output_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_pins_input: assert property (!hardware_reset_low_i |=> code_addr_oe_n_o)
        else $error("address pins driven in hardware reset");
    chk_capture_word: assert property ($rose(hardware_reset_low_i) |-> ##2
        (config_valid_o && !code_addr_oe_n_o && config_word_o == $past(code_addr_i, 2)))
        else $error("strap word not captured at release");
    chk_word_holds: assert property (config_valid_o && hardware_reset_low_i &&
        $past(hardware_reset_low_i) && $past(hardware_reset_low_i, 2) |=> $stable(config_word_o))
        else $error("stored word changed without reset");
    chk_host_read: assert property (host_read_i |=>
        host_read_valid_o && host_read_data_o == $past(config_word_o))
        else $error("host read answer wrong");
    chk_read_pulse: assert property (!host_read_i |=> !host_read_valid_o)
        else $error("host read valid without request");
    chk_slave_addr: assert property (config_valid_o |-> host_slave_addr_o == config_word_o[6:0])
        else $error("slave address decode wrong");
    chk_two_wire: assert property (config_valid_o |->
        host_two_wire_o == (config_word_o[8:7] == 2'b00))
        else $error("two-wire decode wrong");
    chk_setting_fields: assert property (config_valid_o |->
        {code_store_layout_o, refclk_source_o, display_channel_pair_o, baud_choice_o}
        == config_word_o[14:10])
        else $error("setting field decode wrong");
    chk_bias_level: assert property (config_valid_o |-> panel_bias_output_o == config_word_o[15])
        else $error("panel bias level wrong");
    chk_boot_start: assert property (mcu_start_addr_o == 16'h0000 &&
        (!boot_external_o || !config_word_o[14]))
        else $error("boot start or probe wrong");
    chk_run_sticky: assert property (mcu_run_o && hardware_reset_low_i |=> mcu_run_o)
        else $error("controller run dropped");
endmodule

`default_nettype wire

// [sim/rsld_board.sv]
// Board model: strap pull resistors and a code memory with optional signature.
`timescale 1ns/1ps
`default_nettype none

module rsld_board
(
    // Board setup
    input wire logic [15:0] pull_up_i,
    input wire logic sig_present_i,
    // Device pins
    input wire logic [15:0] code_addr_o,
    input wire logic code_addr_oe_n_o,
    output logic [15:0] code_addr_i,
    output logic [7:0] code_data_i
);
    logic [7:0] sig_byte;

    // Released pins settle to their pull level: up where fitted, down elsewhere.
    assign code_addr_i = code_addr_oe_n_o ? pull_up_i : code_addr_o;
    assign sig_byte = code_addr_o[1] ? (code_addr_o[0] ? 8'hef : 8'hcd)
        : (code_addr_o[0] ? 8'hab : 8'h89);
    // Outside the signature the memory returns a pattern that moves with the address.
    assign code_data_i = (sig_present_i && code_addr_o[15:2] == 14'h3fff) ? sig_byte
        : ~code_addr_o[7:0];
endmodule

`default_nettype wire

// [sim/rsld_testbench.sv]
// Self-checking bench for the strap latch and decoder.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_i = 1'b0, reset_i = 1'b1, hardware_reset_low_i = 1'b0, host_read_i = 1'b0;
    logic layout_split_i = 1'b0, mcu_enable_i = 1'b0, mcu_clock_stable_i = 1'b0;
    logic sig_present = 1'b0;
    logic [15:0] pull_up = 16'h0000, fetch_addr_i = 16'h0000;
    logic [15:0] code_addr_i, code_addr_o, config_word_o, mcu_start_addr_o, host_read_data_o;
    logic [7:0] code_data_i;
    logic [6:0] host_slave_addr_o;
    logic [1:0] baud_choice_o;
    logic code_addr_oe_n_o, config_valid_o, mcu_run_o, fetch_external_o, boot_external_o;
    logic host_read_valid_o, host_two_wire_o, display_channel_pair_o, refclk_source_o;
    logic code_store_layout_o, panel_bias_output_o;
    int fail_count = 0, total_checks = 0;

    always #2.5 clk_i = ~clk_i;

    rsld_top dut (.clk_i(clk_i), .reset_i(reset_i), .hardware_reset_low_i(hardware_reset_low_i),
        .code_addr_i(code_addr_i), .code_addr_o(code_addr_o), .code_addr_oe_n_o(code_addr_oe_n_o),
        .code_data_i(code_data_i), .fetch_addr_i(fetch_addr_i), .layout_split_i(layout_split_i),
        .mcu_enable_i(mcu_enable_i), .mcu_clock_stable_i(mcu_clock_stable_i),
        .config_word_o(config_word_o), .config_valid_o(config_valid_o), .mcu_run_o(mcu_run_o),
        .fetch_external_o(fetch_external_o), .boot_external_o(boot_external_o),
        .mcu_start_addr_o(mcu_start_addr_o), .host_read_i(host_read_i),
        .host_read_data_o(host_read_data_o), .host_read_valid_o(host_read_valid_o),
        .host_slave_addr_o(host_slave_addr_o), .host_two_wire_o(host_two_wire_o),
        .display_channel_pair_o(display_channel_pair_o), .baud_choice_o(baud_choice_o),
        .refclk_source_o(refclk_source_o), .code_store_layout_o(code_store_layout_o),
        .panel_bias_output_o(panel_bias_output_o));

    rsld_board board (.pull_up_i(pull_up), .sig_present_i(sig_present),
        .code_addr_o(code_addr_o), .code_addr_oe_n_o(code_addr_oe_n_o),
        .code_addr_i(code_addr_i), .code_data_i(code_data_i));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want)
        begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // -------------------------------------------------------------
    // Watchdog
    // -------------------------------------------------------------
    initial
    begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        print_verdict();
    end

    // -------------------------------------------------------------
    // Strap scenarios
    // -------------------------------------------------------------
    initial
    begin
        logic [15:0] s;
        logic [4:0] f;
        logic en, stb, fx;
        s = $urandom(11529);
        repeat (20) @(negedge clk_i);
        reset_i = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            s = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
            if (i > 1)
                s[14] = i[0];
            if (i == 2)
                s[8:7] = 2'b00;
            en = 1'($urandom);
            stb = 1'($urandom);
            if (i == 5)
            begin
                reset_i = 1'b1;
                @(negedge clk_i);
                check(config_word_o, 16'h0000);
                reset_i = 1'b0;
            end
            hardware_reset_low_i = 1'b0;
            pull_up = s;
            mcu_enable_i = en;
            mcu_clock_stable_i = stb;
            sig_present = i[1];
            layout_split_i = 1'($urandom);
            repeat (3) @(negedge clk_i);
            check(code_addr_oe_n_o, 16'h0001);
            check(config_valid_o, 16'h0000);
            hardware_reset_low_i = 1'b1;
            repeat (3) @(negedge clk_i);
            // Straps now move to show that the stored word ignores them.
            pull_up = ~s;
            f = {code_store_layout_o, refclk_source_o, display_channel_pair_o, baud_choice_o};
            check(config_word_o, s);
            check(code_addr_oe_n_o, 16'h0000);
            check(host_slave_addr_o, s[6:0]);
            check(host_two_wire_o, s[8:7] == 2'b00);
            check(f, s[14:10]);
            check(panel_bias_output_o, s[15]);
            check(mcu_start_addr_o, 16'h0000);
            host_read_i = 1'b1;
            repeat (2) @(negedge clk_i);
            host_read_i = 1'b0;
            check(host_read_valid_o, 16'h0001);
            check(host_read_data_o, s);
            repeat (2) @(negedge clk_i);
            check(host_read_valid_o, 16'h0000);
            fetch_addr_i = 16'($urandom);
            repeat (120) @(negedge clk_i);
            fx = s[14] ? (layout_split_i ? fetch_addr_i[15] : 1'b1) : i[1];
            check(config_word_o, s);
            check(boot_external_o, !s[14] && i[1]);
            check(fetch_external_o, fx);
            check(code_addr_o, (s[14] && layout_split_i && fetch_addr_i[15])
                ? {2'b00, fetch_addr_i[13:0]} : fetch_addr_i);
            check(mcu_run_o, s[9] ? stb : en);
            mcu_enable_i = 1'b1;
            mcu_clock_stable_i = 1'b1;
            repeat (4) @(negedge clk_i);
            mcu_enable_i = 1'b0;
            mcu_clock_stable_i = 1'b0;
            repeat (4) @(negedge clk_i);
            check(mcu_run_o, 16'h0001);
        end
        print_verdict();
    end
endmodule

bind rsld_top rsld_asserts chk (.clk_i(clk_i), .reset_i(reset_i),
    .hardware_reset_low_i(hardware_reset_low_i), .code_addr_i(code_addr_i),
    .code_addr_oe_n_o(code_addr_oe_n_o), .host_read_i(host_read_i),
    .host_read_data_o(host_read_data_o), .host_read_valid_o(host_read_valid_o),
    .config_word_o(config_word_o), .config_valid_o(config_valid_o), .mcu_run_o(mcu_run_o),
    .boot_external_o(boot_external_o), .mcu_start_addr_o(mcu_start_addr_o),
    .host_slave_addr_o(host_slave_addr_o), .host_two_wire_o(host_two_wire_o),
    .display_channel_pair_o(display_channel_pair_o), .baud_choice_o(baud_choice_o),
    .refclk_source_o(refclk_source_o), .code_store_layout_o(code_store_layout_o),
    .panel_bias_output_o(panel_bias_output_o));

`default_nettype wire
